// ### fst_top.sv
// Operation
// RULE1: input one break fails when input one used
// RULE2: input two break fails when input two used
// RULE3: converter fault always enters failure mode
// RULE4: outputs transfer at power start, failure, manual, calibration
// RULE5: output one bumpless uses averaged control value
// RULE6: output one fixed setting drives output one
// RULE7: on-off output one: reverse off, direct on
// RULE8: cooling output two bumpless uses averaged value
// RULE9: cooling output two fixed setting drives output
// RULE10: alarms take own fail state in failure
// RULE11: loop or sensor break alarms forced on
// RULE12: dwell timer alarm keeps normal behaviour
// RULE13: only failure mode transfers the alarms
// RULE14: output two bumpless only when cooling
// RULE15: transfer switches to open loop control
// RULE16: self-tune perturbs, keeps or reverses direction; default off
// RULE17: tuned values stored into event-selected set
// RULE18: completion clears self-tune enable
// RULE19: self-tune stops at once on disable conditions
// RULE20: autotune results seed self-tune values
// RULE21: self-tune stays pid, tolerates set-point changes
// RULE22: on-off output one never enters manual
// RULE23: running average kept during closed loop
`timescale 1ns/1ps
`include "fst_cfg.svh"
module fst_top #(
	parameter int PS_CYC = `FST_PS_MS * `FST_CLK_MHZ * 1000
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [5:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	input  wire logic        input_one_break_error,
	input  wire logic        input_two_break_error,
	input  wire logic        converter_fault_error,
	input  wire logic        event_set_select,
	input  wire logic [9:0]  control_var_first,
	input  wire logic [9:0]  control_var_second,
	input  wire logic        alarm_one_normal,
	input  wire logic        alarm_two_normal,
	input  wire logic        loop_break,
	input  wire logic        pid_cycle,
	input  wire logic [15:0] control_cost,
	input  wire logic        autotune_done,
	input  wire logic [15:0] autotune_pb,
	input  wire logic [15:0] autotune_ti,
	input  wire logic [15:0] autotune_td,
	output logic      [9:0]  out_one_level,
	output logic      [9:0]  out_two_level,
	output logic             alarm_one,
	output logic             alarm_two,
	output logic             open_loop,
	output logic             failure_mode,
	output logic      [15:0] pid_prop_band,
	output logic      [15:0] pid_integral_time,
	output logic      [15:0] pid_derivative_time
);
	localparam int SAMPLE_CYC = `FST_SAMPLE_US * `FST_CLK_MHZ;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic [3:0] pin_raw;
	logic [3:0] pin_meta;
	logic [3:0] pin_sync;

	assign pin_raw = {event_set_select, converter_fault_error,
		input_two_break_error, input_one_break_error};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	logic sb_one;
	logic sb_two;
	logic adc_fault;
	logic set_sel;

	assign sb_one    = pin_sync[0];
	assign sb_two    = pin_sync[1];
	assign adc_fault = pin_sync[2];
	assign set_sel   = pin_sync[3];

	// ************************************************************
	// registers
	// ************************************************************
	logic [17:0] ctrl;
	logic [9:0]  fix_one;
	logic [9:0]  fix_two;
	logic [15:0] pb [2];
	logic [15:0] ti [2];
	logic [15:0] td [2];
	logic        tune_done;
	logic        tune_active;
	logic [15:0] work_pb;
	logic [15:0] work_ti;
	logic [15:0] work_td;
	logic        at_load;

	// self-tune enable resets to disabled; a same-cycle write to the control or failure-value register wins
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ctrl    <= `FST_CTRL_RST; // RULE16
			fix_one <= `FST_FAIL_RST;
			fix_two <= `FST_FAIL_RST;
		end else if (reg_write && reg_addr == `FST_A_CTRL) begin
			ctrl <= reg_wdata[17:0];
		end else if (reg_write && reg_addr == `FST_A_FAIL) begin
			fix_one <= reg_wdata[9:0];
			fix_two <= reg_wdata[25:16];
		end else if (tune_done) begin
			ctrl[`FST_B_SELF] <= 1'b0; // RULE18
		end
	end

	// the event input picks which set receives tuning results
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pb <= '{`FST_PB_RST, `FST_PB_RST};
			ti <= '{`FST_TI_RST, `FST_TI_RST};
			td <= '{`FST_TD_RST, `FST_TD_RST};
		end else if (tune_done) begin
			pb[set_sel] <= work_pb; // RULE17
			ti[set_sel] <= work_ti;
			td[set_sel] <= work_td;
		end else if (autotune_done) begin
			pb[set_sel] <= autotune_pb;
			ti[set_sel] <= autotune_ti;
			td[set_sel] <= autotune_td;
		end else if (reg_write) begin
			if (reg_addr == `FST_A_PB1) begin
				pb[0] <= reg_wdata[15:0];
			end else if (reg_addr == `FST_A_TI1) begin
				ti[0] <= reg_wdata[15:0];
			end else if (reg_addr == `FST_A_TD1) begin
				td[0] <= reg_wdata[15:0];
			end else if (reg_addr == `FST_A_PB2) begin
				pb[1] <= reg_wdata[15:0];
			end else if (reg_addr == `FST_A_TI2) begin
				ti[1] <= reg_wdata[15:0];
			end else if (reg_addr == `FST_A_TD2) begin
				td[1] <= reg_wdata[15:0];
			end
		end
	end

	// ************************************************************
	// failure and transfer conditions
	// ************************************************************
	fst_pkg::fst_pv_e  pv_sel;
	fst_pkg::fst_sp_e  sp_sel;
	fst_pkg::fst_alm_e fn_one;
	fst_pkg::fst_alm_e fn_two;
	logic              used_one;
	logic              used_two;
	logic              next_failure;
	logic              onoff_one;
	logic              manual_active;
	logic              power_start;
	logic              transfer;
	logic [28:0]       ps_cnt;

	assign pv_sel = fst_pkg::fst_pv_e'(ctrl[`FST_B_PVS +: 2]);
	assign sp_sel = fst_pkg::fst_sp_e'(ctrl[`FST_B_SPS +: 2]);
	assign fn_one = fst_pkg::fst_alm_e'(ctrl[`FST_B_ALARM_ONE_FUNCTION +: 2]);
	assign fn_two = fst_pkg::fst_alm_e'(ctrl[`FST_B_ALARM_TWO_FUNCTION +: 2]);

	// break thresholds are judged by the input stage before the flag
	assign used_one = pv_sel != fst_pkg::FST_PV_TWO || sp_sel == fst_pkg::FST_SP_ONE;
	assign used_two = pv_sel != fst_pkg::FST_PV_ONE || sp_sel == fst_pkg::FST_SP_TWO;
	assign next_failure = (sb_one && used_one) // RULE1
		|| (sb_two && used_two) // RULE2
		|| adc_fault; // RULE3

	assign onoff_one     = pb[set_sel] == 16'h0000;
	assign manual_active = ctrl[`FST_B_MAN] && !onoff_one; // RULE22
	assign transfer      = power_start || failure_mode || manual_active
		|| ctrl[`FST_B_CAL]; // RULE4

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			failure_mode <= 1'b0;
		end else begin
			failure_mode <= next_failure;
		end
	end

	// long count; shorten PS_CYC in simulation
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ps_cnt      <= 29'h0000000;
			power_start <= 1'b1;
		end else if (power_start) begin
			ps_cnt      <= ps_cnt + 29'h0000001;
			power_start <= ps_cnt != 29'(PS_CYC - 1); // RULE4
		end
	end

	// ************************************************************
	// averaging of control variables
	// ************************************************************
	logic [7:0] smp_cnt;
	logic       sample;
	logic [9:0] avg_one;
	logic [9:0] avg_two;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			smp_cnt <= 8'h00;
			sample  <= 1'b0;
		end else begin
			sample  <= smp_cnt == 8'(SAMPLE_CYC - 1);
			smp_cnt <= (smp_cnt == 8'(SAMPLE_CYC - 1)) ? 8'h00 : smp_cnt + 8'h01;
		end
	end

	fst_avg u_avg_one (
		.ref_clk (ref_clk),
		.rst     (rst),
		.sample  (sample),
		.hold    (transfer),
		.value   (control_var_first),
		.average (avg_one)
	);

	fst_avg u_avg_two (
		.ref_clk (ref_clk),
		.rst     (rst),
		.sample  (sample),
		.hold    (transfer),
		.value   (control_var_second),
		.average (avg_two)
	);

	// ************************************************************
	// output and alarm transfer
	// ************************************************************
	logic cooling_function;

	assign cooling_function = ctrl[`FST_B_COOLING_FUNCTION];

	// bumpless holds only while the load is steady; alarms should back it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_one_level <= 10'h000;
			out_two_level <= 10'h000;
			open_loop     <= 1'b1;
		end else begin
			open_loop <= transfer; // RULE15
			if (!transfer) begin
				out_one_level <= control_var_first;
			end else if (onoff_one) begin
				out_one_level <= ctrl[`FST_B_DIR] ? `FST_FULL : 10'h000; // RULE7
			end else if (ctrl[`FST_B_BP1]) begin
				out_one_level <= avg_one; // RULE5
			end else begin
				out_one_level <= fix_one; // RULE6
			end
			if (!transfer || !cooling_function) begin
				out_two_level <= control_var_second; // RULE14
			end else if (ctrl[`FST_B_BP2]) begin
				out_two_level <= avg_two; // RULE8
			end else begin
				out_two_level <= fix_two; // RULE9
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			alarm_one <= 1'b0;
			alarm_two <= 1'b0;
		end else begin
			if (!failure_mode || fn_one == fst_pkg::FST_AF_DWELL) begin
				alarm_one <= alarm_one_normal; // RULE12 RULE13
			end else if (fn_one == fst_pkg::FST_AF_LOOP || fn_one == fst_pkg::FST_AF_SENS) begin
				alarm_one <= 1'b1; // RULE11
			end else begin
				alarm_one <= ctrl[`FST_B_A1FS]; // RULE10
			end
			if (!failure_mode || fn_two == fst_pkg::FST_AF_DWELL) begin
				alarm_two <= alarm_two_normal; // RULE12 RULE13
			end else if (fn_two == fst_pkg::FST_AF_LOOP || fn_two == fst_pkg::FST_AF_SENS) begin
				alarm_two <= 1'b1; // RULE11
			end else begin
				alarm_two <= ctrl[`FST_B_A2FS]; // RULE10
			end
		end
	end

	// ************************************************************
	// self-tuning
	// ************************************************************
	logic self_run;

	assign self_run = ctrl[`FST_B_SELF] && pb[set_sel] != 16'h0000
		&& ti[set_sel] != 16'h0000 && !loop_break && !failure_mode
		&& !manual_active && !ctrl[`FST_B_SLEEP] && !ctrl[`FST_B_CAL]; // RULE19

	// one cycle late so the stored autotune set is already in place
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			at_load <= 1'b0;
		end else begin
			at_load <= autotune_done; // RULE20
		end
	end

	fst_tune u_tune (
		.ref_clk  (ref_clk),
		.rst      (rst),
		.run      (self_run),
		.cycle    (pid_cycle),
		.cost     (control_cost),
		.load     (at_load),
		.start_pb (pb[set_sel]),
		.start_ti (ti[set_sel]),
		.start_td (td[set_sel]),
		.work_pb  (work_pb),
		.work_ti  (work_ti),
		.work_td  (work_td),
		.active   (tune_active),
		.done     (tune_done)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pid_prop_band       <= 16'h0000;
			pid_integral_time   <= 16'h0000;
			pid_derivative_time <= 16'h0000;
		end else begin
			pid_prop_band       <= tune_active ? work_pb : pb[set_sel]; // RULE16
			pid_integral_time   <= tune_active ? work_ti : ti[set_sel];
			pid_derivative_time <= tune_active ? work_td : td[set_sel];
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (!reg_read) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_addr == `FST_A_CTRL) begin
			reg_rdata <= {14'h0000, ctrl};
		end else if (reg_addr == `FST_A_FAIL) begin
			reg_rdata <= {6'h00, fix_two, 6'h00, fix_one};
		end else if (reg_addr == `FST_A_PB1) begin
			reg_rdata <= {16'h0000, pb[0]};
		end else if (reg_addr == `FST_A_TI1) begin
			reg_rdata <= {16'h0000, ti[0]};
		end else if (reg_addr == `FST_A_TD1) begin
			reg_rdata <= {16'h0000, td[0]};
		end else if (reg_addr == `FST_A_PB2) begin
			reg_rdata <= {16'h0000, pb[1]};
		end else if (reg_addr == `FST_A_TI2) begin
			reg_rdata <= {16'h0000, ti[1]};
		end else if (reg_addr == `FST_A_TD2) begin
			reg_rdata <= {16'h0000, td[1]};
		end else if (reg_addr == `FST_A_STAT) begin
			reg_rdata <= {26'h0000000, set_sel, tune_active, manual_active,
				power_start, transfer, failure_mode};
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ************************************************************
	// checks
	// ************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence s_enter_fail;
		!failure_mode ##1 failure_mode;
	endsequence

	property p_fail_one;
		sb_one && used_one |=> failure_mode;
	endproperty
	a_fail_one: assert property (p_fail_one) else $error("input one break missed"); // RULE1

	property p_fail_two;
		sb_two && used_two |=> failure_mode;
	endproperty
	a_fail_two: assert property (p_fail_two) else $error("input two break missed"); // RULE2

	property p_fail_adc;
		adc_fault |=> failure_mode ##1 open_loop;
	endproperty
	a_fail_adc: assert property (p_fail_adc) else $error("converter fault missed"); // RULE3

	property p_xfer;
		transfer |=> open_loop;
	endproperty
	a_xfer: assert property (p_xfer) else $error("no open loop in transfer"); // RULE4

	property p_bump_one;
		transfer && !onoff_one && ctrl[`FST_B_BP1] |=> out_one_level == $past(avg_one);
	endproperty
	a_bump_one: assert property (p_bump_one) else $error("output one not bumpless"); // RULE5

	property p_onoff;
		transfer && onoff_one |=> out_one_level == ($past(ctrl[`FST_B_DIR]) ? `FST_FULL : 10'h000);
	endproperty
	a_onoff: assert property (p_onoff) else $error("on-off transfer wrong"); // RULE7

	property p_fix_two;
		transfer && cooling_function && !ctrl[`FST_B_BP2] |=> out_two_level == $past(fix_two);
	endproperty
	a_fix_two: assert property (p_fix_two) else $error("output two fixed value wrong"); // RULE9

	property p_alarm_fs;
		s_enter_fail ##0 fn_one == fst_pkg::FST_AF_OTHER
			|=> alarm_one == $past(ctrl[`FST_B_A1FS]);
	endproperty
	a_alarm_fs: assert property (p_alarm_fs) else $error("alarm one fail state wrong"); // RULE10

	property p_alarm_brk;
		failure_mode && (fn_two == fst_pkg::FST_AF_LOOP || fn_two == fst_pkg::FST_AF_SENS)
			|=> alarm_two;
	endproperty
	a_alarm_brk: assert property (p_alarm_brk) else $error("break alarm not forced"); // RULE11

	property p_alarm_norm;
		!failure_mode |=> alarm_one == $past(alarm_one_normal);
	endproperty
	a_alarm_norm: assert property (p_alarm_norm) else $error("alarm moved outside failure"); // RULE13

	// with on-off output one, a manual request alone must not open the loop
	property p_manual;
		onoff_one && !ctrl[`FST_B_CAL] && !failure_mode && !power_start |=> !open_loop;
	endproperty
	a_manual: assert property (p_manual) else $error("manual entered with on-off"); // RULE22

	property p_self_clr;
		tune_done && !reg_write |=> !ctrl[`FST_B_SELF] && pb[$past(set_sel)] == $past(work_pb);
	endproperty
	a_self_clr: assert property (p_self_clr) else $error("tune completion wrong"); // RULE17 RULE18
endmodule : fst_top

// ### fst_cfg.svh
`ifndef FST_CFG_SVH
`define FST_CFG_SVH
// ************************************************************
// register offsets
// ************************************************************
`define FST_A_CTRL 6'h00
`define FST_A_FAIL 6'h04
`define FST_A_PB1 6'h08
`define FST_A_TI1 6'h0c
`define FST_A_TD1 6'h10
`define FST_A_PB2 6'h14
`define FST_A_TI2 6'h18
`define FST_A_TD2 6'h1c
`define FST_A_STAT 6'h20
// ************************************************************
// control field positions
// ************************************************************
`define FST_B_SELF 0
`define FST_B_MAN 1
`define FST_B_CAL 2
`define FST_B_SLEEP 3
`define FST_B_DIR 4
`define FST_B_COOLING_FUNCTION 5
`define FST_B_BP1 6
`define FST_B_BP2 7
`define FST_B_A1FS 8
`define FST_B_A2FS 9
`define FST_B_ALARM_ONE_FUNCTION 10
`define FST_B_ALARM_TWO_FUNCTION 12
`define FST_B_PVS 14
`define FST_B_SPS 16
// ************************************************************
// reset values and scaling
// ************************************************************
`define FST_CTRL_RST 18'h00000
`define FST_FAIL_RST 10'h000
`define FST_PB_RST 16'h00b4
`define FST_TI_RST 16'h0064
`define FST_TD_RST 16'h00fa
`define FST_FULL 10'h3e8
// ************************************************************
// timing
// ************************************************************
`define FST_CLK_MHZ 200
`define FST_PS_MS 2500
`define FST_SAMPLE_US 1
`define FST_AVG_SHIFT 4
`define FST_ST_SHIFT 4
`define FST_ST_REVS 4'h4
`endif

// ### fst_pkg.sv
package fst_pkg;
	typedef enum logic [1:0] {
		FST_ST_IDLE = 2'b00,
		FST_ST_RUN  = 2'b01,
		FST_ST_DONE = 2'b11
	} fst_tune_e;
	typedef enum logic [1:0] {
		FST_AF_OTHER = 2'h0,
		FST_AF_LOOP  = 2'h1,
		FST_AF_SENS  = 2'h2,
		FST_AF_DWELL = 2'h3
	} fst_alm_e;
	typedef enum logic [1:0] {
		FST_PV_ONE = 2'h0,
		FST_PV_TWO = 2'h1,
		FST_PV_DIF = 2'h2,
		FST_PV_RDF = 2'h3
	} fst_pv_e;
	typedef enum logic [1:0] {
		FST_SP_INT = 2'h0,
		FST_SP_ONE = 2'h1,
		FST_SP_TWO = 2'h2,
		FST_SP_OTH = 2'h3
	} fst_sp_e;
endpackage : fst_pkg

// ### fst_avg.sv
`timescale 1ns/1ps
`include "fst_cfg.svh"
module fst_avg (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	input  wire logic       sample,
	input  wire logic       hold,
	input  wire logic [9:0] value,
	output logic      [9:0] average
);
	// acc holds the average scaled by 2**shift, so no fraction is lost
	logic [13:0] acc;
	logic [14:0] next_acc;

	always_comb begin
		next_acc = {1'b0, acc} + {5'h00, value} - {5'h00, acc[13:`FST_AVG_SHIFT]};
	end

	// frozen while held, so the stored value is the one from before the upset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc <= 14'h0000;
		end else if (sample && !hold) begin
			acc <= next_acc[13:0]; // RULE23
		end
	end

	assign average = acc[13:`FST_AVG_SHIFT];
endmodule : fst_avg

// ### fst_tune.sv
`timescale 1ns/1ps
`include "fst_cfg.svh"
module fst_tune (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        run,
	input  wire logic        cycle,
	input  wire logic [15:0] cost,
	input  wire logic        load,
	input  wire logic [15:0] start_pb,
	input  wire logic [15:0] start_ti,
	input  wire logic [15:0] start_td,
	output logic      [15:0] work_pb,
	output logic      [15:0] work_ti,
	output logic      [15:0] work_td,
	output logic             active,
	output logic             done
);
	fst_pkg::fst_tune_e state;
	logic               up;
	logic [15:0]        prev_cost;
	logic [3:0]         revs;
	logic               better;

	// a step proportional to the value keeps the perturbation gentle
	function automatic logic [15:0] nudge(input logic [15:0] v, input logic dir);
		logic [15:0] step;
		step = (v >> `FST_ST_SHIFT) + 16'h0001;
		if (dir) begin
			nudge = (v > 16'hffff - step) ? v : v + step;
		end else begin
			nudge = (v > step) ? v - step : v;
		end
	endfunction : nudge

	assign better = cost < prev_cost;
	assign active = (state == fst_pkg::FST_ST_RUN);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= fst_pkg::FST_ST_IDLE;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				fst_pkg::FST_ST_IDLE: begin
					if (run) begin
						state <= fst_pkg::FST_ST_RUN;
					end
				end
				fst_pkg::FST_ST_RUN: begin
					if (!run) begin
						state <= fst_pkg::FST_ST_IDLE; // RULE19
					end else if (cycle && !better && revs == `FST_ST_REVS - 4'h1) begin
						state <= fst_pkg::FST_ST_DONE;
						done  <= 1'b1; // RULE18
					end
				end
				default: begin
					state <= fst_pkg::FST_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			work_pb   <= 16'h0000;
			work_ti   <= 16'h0000;
			work_td   <= 16'h0000;
			up        <= 1'b1;
			prev_cost <= 16'hffff;
			revs      <= 4'h0;
		end else if (state == fst_pkg::FST_ST_IDLE || load) begin
			// autotune results become the new starting point
			work_pb   <= start_pb; // RULE20
			work_ti   <= start_ti;
			work_td   <= start_td;
			up        <= 1'b1;
			prev_cost <= 16'hffff;
			revs      <= 4'h0;
		end else if (active && cycle) begin
			// set-point moves are not watched; only the cost matters
			work_pb   <= nudge(work_pb, better ? up : !up); // RULE16 RULE21
			work_ti   <= nudge(work_ti, better ? up : !up);
			work_td   <= nudge(work_td, better ? up : !up);
			up        <= better ? up : !up;
			prev_cost <= cost;
			revs      <= better ? revs : revs + 4'h1;
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_abort;
		active && !run |=> state == fst_pkg::FST_ST_IDLE && !done;
	endproperty
	a_abort: assert property (p_abort) else $error("tuning kept running"); // RULE19

	property p_reverse;
		active && run && cycle && !better && !load |=> up != $past(up);
	endproperty
	a_reverse: assert property (p_reverse) else $error("direction not reversed"); // RULE16
endmodule : fst_tune

// ### fst_plant.sv
`timescale 1ns/1ps
// ************************************************************
// process side stand-in
// ************************************************************
module fst_plant (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	output logic      [9:0]  control_var_first,
	output logic      [9:0]  control_var_second,
	output logic             alarm_one_normal,
	output logic             alarm_two_normal,
	output logic             pid_cycle,
	output logic      [15:0] control_cost
);
	logic [2:0] div;
	// constant loop outputs keep the running averages predictable
	assign control_var_first  = 10'h200;
	assign control_var_second = 10'h155;
	assign alarm_one_normal   = 1'b0;
	assign alarm_two_normal   = 1'b0;
	// cost alternates so the tuner both keeps and reverses direction
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div          <= 3'h0;
			pid_cycle    <= 1'b0;
			control_cost <= 16'h0100;
		end else begin
			div       <= div + 3'h1;
			pid_cycle <= (div == 3'h7);
			if (div == 3'h7) begin
				control_cost <= control_cost ^ 16'h0037;
			end
		end
	end
endmodule : fst_plant

// ### failure_transfer_selftune_tb.sv
`timescale 1ns/1ps
module failure_transfer_selftune_tb;
	typedef struct packed {logic [17:0] c; logic [2:0] e; logic [2:0] x;} fst_row_s;
	logic        ref_clk, rst, reg_write, reg_read, loop_break, autotune_done;
	logic        input_one_break_error, input_two_break_error, converter_fault_error;
	logic        event_set_select, alarm_one_normal, alarm_two_normal, pid_cycle;
	logic        alarm_one, alarm_two, open_loop, failure_mode;
	logic [5:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [9:0]  control_var_first, control_var_second, out_one_level, out_two_level;
	logic [15:0] control_cost, autotune_pb, autotune_ti, autotune_td;
	logic [15:0] pid_prop_band, pid_integral_time, pid_derivative_time;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;
	fst_row_s    rows [7];

	fst_top #(.PS_CYC(50)) i_dut (.*);
	fst_plant i_plant (.*);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// ************************************************************
	// tasks
	// ************************************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : wt
	task automatic wr(input logic [5:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge ref_clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, output logic [31:0] q);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		q = reg_rdata;
	endtask : rd
	task automatic finish_test;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	// a hang is cut short well past the longest expected run
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			finish_test;
		end
	end
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		{reg_addr, reg_wdata, reg_write, reg_read, input_one_break_error, input_two_break_error,
			converter_fault_error, event_set_select, loop_break, autotune_done, autotune_pb,
			autotune_ti, autotune_td} = '0;
		// errors {adc, in2, in1}; expect {failure, alarm one, alarm two}
		rows = '{'{18'h03300, 3'h1, 3'h6}, '{18'h04700, 3'h1, 3'h0}, '{18'h06400, 3'h2, 3'h7},
			'{18'h20000, 3'h2, 3'h4}, '{18'h08200, 3'h2, 3'h5}, '{18'h00000, 3'h2, 3'h0},
			'{18'h04000, 3'h4, 3'h4}};
		wt(6);
		rst <= 1'b0;
		wt(2);
		check(32'(pid_prop_band), 32'h00b4);
		check(32'(pid_integral_time), 32'h0064);
		check(32'(pid_derivative_time), 32'h00fa);
		rd(6'h00, d);
		check(d, 32'h0);
		wt(20);
		check(32'({open_loop, out_one_level}), 32'h400);
		wt(40);
		check(32'(open_loop), 32'h0);
		foreach (rows[i]) begin
			wr(6'h00, 32'(rows[i].c));
			{converter_fault_error, input_two_break_error, input_one_break_error} <= rows[i].e;
			wt(6);
			check(32'({failure_mode, alarm_one, alarm_two}),
				32'(rows[i].x));
			{converter_fault_error, input_two_break_error, input_one_break_error} <= 3'h0;
			wt(6);
		end
		wr(6'h04, 32'h01f4_0064);
		wr(6'h00, 32'h20);
		converter_fault_error <= 1'b1;
		wt(6);
		check(32'({open_loop, out_one_level, out_two_level}), 32'h0011_91f4);
		converter_fault_error <= 1'b0;
		wr(6'h00, 32'h302);
		wt(6);
		check(32'({open_loop, alarm_one, alarm_two, out_one_level, out_two_level}),
			32'({3'h4, 10'h064, 10'h155}));
		wr(6'h08, 32'h0);
		wr(6'h00, 32'h14);
		wt(3);
		check(32'({open_loop, out_one_level}), 32'h7e8);
		wr(6'h00, 32'h04);
		wt(3);
		check(32'(out_one_level), 32'h0);
		wr(6'h00, 32'h02);
		wt(3);
		rd(6'h20, d);
		check(32'(d[3]), 32'h0);
		check(32'(open_loop), 32'h0);
		wr(6'h08, 32'h00b4);
		wr(6'h00, 32'h01);
		wt(3);
		rd(6'h20, d);
		check(32'(d[4]), 32'h1);
		wt(20);
		check(32'(pid_prop_band !== 16'h00b4), 32'h1);
		loop_break <= 1'b1;
		wt(3);
		rd(6'h20, d);
		check(32'(d[4]), 32'h0);
		loop_break <= 1'b0;
		wt(150);
		rd(6'h00, d);
		check(32'(d[0]), 32'h0);
		event_set_select <= 1'b1;
		{autotune_pb, autotune_ti, autotune_td} <= {16'h0123, 16'h0045, 16'h0067};
		wt(4);
		autotune_done <= 1'b1;
		wt(1);
		autotune_done <= 1'b0;
		wt(2);
		rd(6'h14, d);
		check(d, 32'h0123);
		wt(20000);
		wr(6'h00, 32'he2);
		wt(4);
		check(32'({out_one_level inside {[10'h1e0:10'h200]}, out_two_level inside
			{[10'h145:10'h155]}}), 32'h3);
		finish_test;
	end
endmodule : failure_transfer_selftune_tb
